// ==== core/ptu_core.sv ====
// Privilege transfer unit: far call/return stack switch, fast enter/exit
//
// Function
// RQ1: 64-bit gate call loads only inner stack pointer, no stack descriptor.
// RQ2: 64-bit gate call forces stack selector null with REQUESTED_PRIV_LEVEL equal new level.
// RQ3: Old stack selector and pointer pushed on inner stack, +24 and +16.
// RQ4: Call frame: return pointer at 0, code selector, pointer, selector above.
// RQ5: 64-bit privilege call/return slots are eight bytes, pointer moves by eight.
// RQ6: 64-bit mode ignores gate parameter count, copies nothing.
// RQ7: 64-bit far return may pop null stack selector when target level not 3.
// RQ8: Near return only checks popped pointer against code limit.
// RQ9: Same-level far return pops selector and pointer, privilege checked.
// RQ10: Level crossing when saved REQUESTED_PRIV_LEVEL above current level; inward refused.
// RQ11: Code selector and pointer loaded from stack after type/privilege checks.
// RQ12: Byte count added after popping code selector and pointer on crossing.
// RQ13: Crossing reloads saved stack; limit or descriptor faults raise GP.
// RQ14: Byte count added again on caller stack without limit check.
// RQ15: Data segment registers more privileged than new level become null.
// RQ16: Fast enter at any level, fast exit only at level 0; no saved state.
// RQ17: Fast enter: code sel from MSR, stack sel plus 8, pointers from MSRs.
// RQ18: Legacy fast exit: selectors MSR plus 16/24, target D, stack C.
// RQ19: Long mode fast enter: flat segments, canonical addresses, non-null CS; code checks null CS only with long code flag set.
// RQ20: Target/stack MSRs hold 64 bits, only low 32 used outside long mode.
// RQ21: Wide fast exit: MSR plus 32 with long code flag, plus 40, 64-bit regs.
// RQ22: 32-bit fast exit in long mode clears long flag, MSR plus 16/24.
// RQ23: GP on fast exit above level 0 or near return past limit.
// RQ24: Far return commits nothing when any check faults.
`timescale 1ns/1ps
module ptu_core
  import ptu_pkg::*;
(
  input wire logic i_clk_sys, // 50 MHz core clock
  input wire logic i_rst_b, // Synchronous reset, active low
  input wire logic [7:0] i_awaddr, // AXI write address
  input wire logic i_awvalid, // AXI write address valid
  output logic o_awready, // AXI write address ready
  input wire logic [31:0] i_wdata, // AXI write data
  input wire logic [3:0] i_wstrb, // AXI write strobes
  input wire logic i_wvalid, // AXI write data valid
  output logic o_wready, // AXI write data ready
  output logic [1:0] o_bresp, // AXI write response
  output logic o_bvalid, // AXI write response valid
  input wire logic i_bready, // AXI write response ready
  input wire logic [7:0] i_araddr, // AXI read address
  input wire logic i_arvalid, // AXI read address valid
  output logic o_arready, // AXI read address ready
  output logic [31:0] o_rdata, // AXI read data
  output logic [1:0] o_rresp, // AXI read response
  output logic o_rvalid, // AXI read data valid
  input wire logic i_rready // AXI read data ready
);
  // ********************************************
  // Bus slave
  // ********************************************
  logic [31:0] regs_q [0:PTU_NREG-1];
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  ptu_state_t state_q;
  logic [3:0] fault_code_q;
  logic busy_q;
  logic done_q;
  logic [4:0] copied_q;

  wire idle = (state_q == PTU_ST_IDLE);
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  // Writes only while idle so a commit never races a bus write
  wire do_write = aw_have_q && w_have_q && !o_bvalid && idle;
  wire [5:0] wr_idx = awaddr_q[7:2];
  wire wr_hit = (wr_idx < 6'(PTU_NREG));
  wire wr_ctrl = do_write && wr_hit && (awaddr_q == PTU_OFF_CTRL);
  wire wr_status = (awaddr_q == PTU_OFF_STATUS);
  wire [5:0] rd_idx = i_araddr[7:2];
  wire rd_hit = (rd_idx < 6'(PTU_NREG));
  wire ar_take = i_arvalid && o_arready;
  wire [31:0] status_word = {15'h0, copied_q, regs_q[PTU_OFF_MODE[7:2]][3:2],
    regs_q[PTU_OFF_MODE[7:2]][1:0], fault_code_q, 2'h0, done_q, busy_q};
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= PTU_RESP_OKAY;
    end else begin
      o_awready <= !aw_have_q && !aw_take && idle;
      o_wready <= !w_have_q && !w_take && idle;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? PTU_RESP_OKAY : PTU_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= PTU_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !ar_take;
      if (ar_take) begin
        o_rvalid <= 1'b1;
        o_rresp <= rd_hit ? PTU_RESP_OKAY : PTU_RESP_SLVERR;
        o_rdata <= !rd_hit ? 32'h0 :
          (i_araddr == PTU_OFF_STATUS) ? status_word : regs_q[rd_idx];
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ********************************************
  // Operand decode
  // ********************************************
  wire [31:0] ctrl = regs_q[PTU_OFF_CTRL[7:2]];
  wire [2:0] op = ctrl[2:0];
  wire wide = ctrl[3];
  wire [31:0] mode = regs_q[PTU_OFF_MODE[7:2]];
  wire [1:0] current_priv_level = mode[1:0];
  wire long_mode = mode[2];
  wire long_code = mode[3];
  wire mode64 = long_mode && long_code;
  wire [15:0] cs_sel = regs_q[PTU_OFF_CS_SEL[7:2]][15:0];
  wire [15:0] ss_sel = regs_q[PTU_OFF_SS_SEL[7:2]][15:0];
  wire [31:0] cs_limit = regs_q[PTU_OFF_CS_LIMIT[7:2]];
  wire [5:0] ip_i = PTU_OFF_IP_LO[7:2];
  wire [5:0] sp_i = PTU_OFF_SP_LO[7:2];
  wire [63:0] cur_ip = {regs_q[ip_i + 6'h1], regs_q[ip_i]};
  wire [63:0] cur_sp = {regs_q[sp_i + 6'h1], regs_q[sp_i]};
  wire [5:0] et_i = PTU_OFF_ENT_TGT_LO[7:2];
  wire [5:0] es_i = PTU_OFF_ENT_SP_LO[7:2];
  wire [63:0] ent_tgt = {regs_q[et_i + 6'h1], regs_q[et_i]};
  wire [63:0] ent_sp = {regs_q[es_i + 6'h1], regs_q[es_i]};
  wire [15:0] ent_cs = regs_q[PTU_OFF_ENT_CS[7:2]][15:0];
  wire [5:0] gd_i = PTU_OFF_GPD_LO[7:2];
  wire [5:0] gc_i = PTU_OFF_GPC_LO[7:2];
  wire [63:0] gp_d = {regs_q[gd_i + 6'h1], regs_q[gd_i]};
  wire [63:0] gp_c = {regs_q[gc_i + 6'h1], regs_q[gc_i]};
  wire [5:0] is_i = PTU_OFF_INNER_SP_LO[7:2];
  wire [63:0] inner_sp = {regs_q[is_i + 6'h1], regs_q[is_i]};
  wire [15:0] inner_ss = regs_q[PTU_OFF_INNER_SS[7:2]][15:0];
  wire [31:0] gate = regs_q[PTU_OFF_GATE[7:2]];
  wire [1:0] gate_cpl = gate[17:16];
  wire [4:0] gate_cnt = gate[22:18];
  wire [31:0] gate_ip = regs_q[PTU_OFF_GATE_IP[7:2]];
  wire [63:0] ret_cnt = {48'h0, regs_q[PTU_OFF_RET_COUNT[7:2]][15:0]};
  wire [31:0] desc = regs_q[PTU_OFF_DESC[7:2]];
  wire [31:0] seg_attr = regs_q[PTU_OFF_SEG_ATTR[7:2]];
  wire [5:0] f_i = PTU_OFF_FRAME0[7:2];
  wire [63:0] slot0 = {regs_q[f_i + 6'h1], regs_q[f_i]};
  wire [63:0] slot1 = {regs_q[f_i + 6'h3], regs_q[f_i + 6'h2]};
  wire [63:0] slot2 = {regs_q[f_i + 6'h5], regs_q[f_i + 6'h4]};
  wire [63:0] slot3 = {regs_q[f_i + 6'h7], regs_q[f_i + 6'h6]};
  wire [63:0] stride = mode64 ? PTU_STRIDE64 : PTU_STRIDE32; // RQ5
  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:47] == {17{a[47]}});
  endfunction
  function automatic logic [63:0] lo32(input logic [63:0] a);
    lo32 = {32'h0, a[31:0]};
  endfunction

  // ********************************************
  // Transfer evaluation
  // ********************************************
  logic [3:0] flt;
  logic [15:0] n_cs;
  logic [15:0] n_ss;
  logic [63:0] n_ip;
  logic [63:0] n_sp;
  logic [1:0] n_cpl;
  logic n_lcf;
  logic [31:0] n_limit;
  logic wr_frame;
  logic [3:0] null_seg;
  logic [4:0] n_copied;
  logic [1:0] requested_priv_level;
  logic [63:0] pop_sp;

  always_comb begin
    flt = PTU_F_NONE;
    n_cs = cs_sel;
    n_ss = ss_sel;
    n_ip = cur_ip;
    n_sp = cur_sp;
    n_cpl = current_priv_level;
    n_lcf = long_code;
    n_limit = cs_limit;
    wr_frame = 1'b0;
    null_seg = 4'h0;
    n_copied = 5'h0;
    requested_priv_level = slot1[1:0];
    pop_sp = cur_sp + (stride << 1) + ret_cnt;
    case (op)
      PTU_OP_CALL: begin
        n_cpl = gate_cpl;
        n_cs = {gate[15:2], gate_cpl};
        n_ip = {32'h0, gate_ip};
        wr_frame = 1'b1; // RQ3 RQ4
        if (mode64) begin
          n_ss = {14'h0, gate_cpl}; // RQ1 RQ2
          n_sp = inner_sp - (stride << 2); // RQ5 RQ6
        end else begin
          n_ss = inner_ss;
          n_copied = gate_cnt;
          n_sp = inner_sp - (stride << 2) - ({59'h0, gate_cnt} << 2);
        end
      end
      PTU_OP_NEAR_RET: begin
        if (slot0[31:0] > cs_limit) begin
          flt = PTU_F_GP_LIMIT; // RQ8 RQ23
        end else begin
          n_ip = mode64 ? slot0 : lo32(slot0);
          n_sp = cur_sp + stride;
        end
      end
      PTU_OP_FAR_RET: begin
        // Checks in step order; first failure wins, nothing commits
        if (requested_priv_level < current_priv_level) begin
          flt = PTU_F_GP_PRIV; // RQ10
        end else if (!desc[2] || desc[1:0] != requested_priv_level) begin
          flt = PTU_F_GP_CODE; // RQ9 RQ11
        end else if (!mode64 && slot0[31:0] > desc[31:8] << 8) begin
          flt = PTU_F_GP_LIMIT;
        end else if (requested_priv_level == current_priv_level) begin
          n_cs = slot1[15:0]; // RQ9
          n_ip = mode64 ? slot0 : lo32(slot0);
          n_sp = pop_sp;
        end else if (slot3[15:2] == 14'h0 && !(mode64 && requested_priv_level != 2'h3)) begin
          flt = PTU_F_GP_NULL; // RQ7
        end else if (slot3[15:2] != 14'h0 &&
            (!desc[3] || desc[5:4] != requested_priv_level || !desc[6])) begin
          flt = PTU_F_GP_STACK; // RQ13
        end else begin
          n_cs = slot1[15:0]; // RQ11
          n_ip = mode64 ? slot0 : lo32(slot0);
          n_cpl = requested_priv_level;
          n_ss = slot3[15:0]; // RQ7 RQ13
          // pop_sp steps past callee parameters to the saved pair
          n_sp = (mode64 ? slot2 : lo32(slot2)) + ret_cnt; // RQ12 RQ14
          for (int s = 0; s < 4; s++) begin
            null_seg[s] = (seg_attr[3*s +: 2] < requested_priv_level) &&
              !seg_attr[3*s + 2]; // RQ15
          end
        end
      end
      PTU_OP_ENTER: begin
        if (mode64 && ent_cs[15:2] == 14'h0) begin
          flt = PTU_F_GP_NULL; // RQ19
        end else if (long_mode && (!canon(ent_tgt) || !canon(ent_sp))) begin
          flt = PTU_F_GP_CANON; // RQ19
        end else begin
          n_cpl = PTU_CPL_KERNEL; // RQ16
          n_cs = ent_cs; // RQ17
          n_ss = ent_cs + PTU_SEL_ENT_SS;
          n_ip = long_mode ? ent_tgt : lo32(ent_tgt); // RQ20
          n_sp = long_mode ? ent_sp : lo32(ent_sp);
          if (long_mode) begin
            n_limit = PTU_FLAT_LIMIT; // RQ19
            n_lcf = 1'b1;
          end
        end
      end
      PTU_OP_EXIT: begin
        if (current_priv_level != PTU_CPL_KERNEL) begin
          flt = PTU_F_GP_PRIV; // RQ16 RQ23
        end else if (long_mode && wide) begin
          if (!canon(gp_d) || !canon(gp_c)) begin
            flt = PTU_F_GP_CANON;
          end else begin
            n_cpl = PTU_CPL_USER;
            n_cs = ent_cs + PTU_SEL_EXIT_CS64; // RQ21
            n_ss = ent_cs + PTU_SEL_EXIT_SS64;
            n_ip = gp_d;
            n_sp = gp_c;
            n_lcf = 1'b1;
          end
        end else begin
          n_cpl = PTU_CPL_USER;
          n_cs = ent_cs + PTU_SEL_EXIT_CS; // RQ18 RQ22
          n_ss = ent_cs + PTU_SEL_EXIT_SS;
          n_ip = lo32(gp_d);
          n_sp = lo32(gp_c);
          n_lcf = 1'b0; // RQ22
        end
      end
      default: begin
        flt = PTU_F_BAD_OP;
      end
    endcase
  end

  // ********************************************
  // Sequencer and register file
  // ********************************************
  logic [3:0] flt_q;
  logic [15:0] n_cs_q;
  logic [15:0] n_ss_q;
  logic [63:0] n_ip_q;
  logic [63:0] n_sp_q;
  logic [1:0] n_cpl_q;
  logic n_lcf_q;
  logic [31:0] n_limit_q;
  logic wr_frame_q;
  logic [3:0] null_seg_q;
  logic [4:0] n_copied_q;
  // Old values captured before commit overwrites them
  logic [63:0] old_ip_q;
  logic [63:0] old_sp_q;
  logic [15:0] old_cs_q;
  logic [15:0] old_ss_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_q <= PTU_ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fault_code_q <= PTU_F_NONE;
      copied_q <= 5'h0;
    end else begin
      case (state_q)
        PTU_ST_IDLE: begin
          if (wr_ctrl) begin
            state_q <= PTU_ST_EXEC;
            busy_q <= 1'b1;
            done_q <= 1'b0;
          end
        end
        PTU_ST_EXEC: begin
          state_q <= PTU_ST_COMMIT;
        end
        PTU_ST_COMMIT: begin
          state_q <= PTU_ST_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          fault_code_q <= flt_q;
          copied_q <= (flt_q == PTU_F_NONE) ? n_copied_q : 5'h0;
        end
        default: begin
          state_q <= PTU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (state_q == PTU_ST_EXEC) begin
      flt_q <= flt;
      n_cs_q <= n_cs;
      n_ss_q <= n_ss;
      n_ip_q <= n_ip;
      n_sp_q <= n_sp;
      n_cpl_q <= n_cpl;
      n_lcf_q <= n_lcf;
      n_limit_q <= n_limit;
      wr_frame_q <= wr_frame;
      null_seg_q <= null_seg;
      n_copied_q <= n_copied;
      old_ip_q <= cur_ip;
      old_sp_q <= cur_sp;
      old_cs_q <= cs_sel;
      old_ss_q <= ss_sel;
    end
  end

  wire commit = (state_q == PTU_ST_COMMIT) && (flt_q == PTU_F_NONE); // RQ24
  wire [63:0] frame_val [0:3];
  assign frame_val[0] = old_ip_q;
  assign frame_val[1] = {48'h0, old_cs_q};
  assign frame_val[2] = old_sp_q;
  assign frame_val[3] = {48'h0, old_ss_q};

  genvar g;
  generate
    for (g = 0; g < PTU_NREG; g++) begin : g_reg
      logic [31:0] cval;
      logic cwe;
      localparam logic [5:0] IDX = 6'(g);
      localparam int FS = (g - int'(PTU_OFF_FRAME0[7:2])) / 2;
      localparam int SS = (g - int'(PTU_OFF_SEG_SEL0[7:2]));
      always_comb begin
        cval = regs_q[g];
        cwe = 1'b0;
        if (IDX == PTU_OFF_CS_SEL[7:2]) begin
          cval = {16'h0, n_cs_q};
          cwe = 1'b1;
        end else if (IDX == PTU_OFF_SS_SEL[7:2]) begin
          cval = {16'h0, n_ss_q};
          cwe = 1'b1;
        end else if (IDX == ip_i || IDX == ip_i + 6'h1) begin
          cval = IDX[0] == ip_i[0] ? n_ip_q[31:0] : n_ip_q[63:32];
          cwe = 1'b1;
        end else if (IDX == sp_i || IDX == sp_i + 6'h1) begin
          cval = IDX[0] == sp_i[0] ? n_sp_q[31:0] : n_sp_q[63:32];
          cwe = 1'b1;
        end else if (IDX == PTU_OFF_MODE[7:2]) begin
          cval = {regs_q[g][31:4], n_lcf_q, regs_q[g][2], n_cpl_q};
          cwe = 1'b1;
        end else if (IDX == PTU_OFF_CS_LIMIT[7:2]) begin
          cval = n_limit_q;
          cwe = 1'b1;
        end else if (FS >= 0 && FS < 4 && g >= int'(f_i)) begin
          cval = ((g - int'(f_i)) % 2 == 0) ? frame_val[FS % 4][31:0] :
            frame_val[FS % 4][63:32];
          cwe = wr_frame_q; // RQ3 RQ4
        end else if (SS >= 0 && SS < 4) begin
          cval = 32'h0;
          cwe = null_seg_q[SS % 4]; // RQ15
        end
      end
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          regs_q[g] <= 32'h0;
        end else if (commit && cwe) begin
          regs_q[g] <= cval;
        end else if (do_write && wr_idx == IDX && !wr_status) begin
          regs_q[g] <= (regs_q[g] & ~wmask) | (wdata_q & wmask);
        end
      end
    end
  endgenerate
endmodule

// ==== core/ptu_pkg.sv ====
// Constants, opcodes and states for the privilege transfer unit
package ptu_pkg;
  // Register byte offsets
  localparam logic [7:0] PTU_OFF_CTRL = 8'h00;
  localparam logic [7:0] PTU_OFF_STATUS = 8'h04;
  localparam logic [7:0] PTU_OFF_MODE = 8'h08;
  localparam logic [7:0] PTU_OFF_CS_SEL = 8'h0c;
  localparam logic [7:0] PTU_OFF_SS_SEL = 8'h10;
  localparam logic [7:0] PTU_OFF_CS_LIMIT = 8'h14;
  localparam logic [7:0] PTU_OFF_IP_LO = 8'h18;
  localparam logic [7:0] PTU_OFF_SP_LO = 8'h20;
  localparam logic [7:0] PTU_OFF_ENT_CS = 8'h28;
  localparam logic [7:0] PTU_OFF_ENT_TGT_LO = 8'h2c;
  localparam logic [7:0] PTU_OFF_ENT_SP_LO = 8'h34;
  localparam logic [7:0] PTU_OFF_GPD_LO = 8'h3c;
  localparam logic [7:0] PTU_OFF_GPC_LO = 8'h44;
  localparam logic [7:0] PTU_OFF_INNER_SP_LO = 8'h4c;
  localparam logic [7:0] PTU_OFF_FRAME0 = 8'h54;
  localparam logic [7:0] PTU_OFF_RET_COUNT = 8'h74;
  localparam logic [7:0] PTU_OFF_DESC = 8'h78;
  localparam logic [7:0] PTU_OFF_SEG_ATTR = 8'h7c;
  localparam logic [7:0] PTU_OFF_SEG_SEL0 = 8'h80;
  localparam logic [7:0] PTU_OFF_GATE = 8'h90;
  localparam logic [7:0] PTU_OFF_GATE_IP = 8'h94;
  localparam logic [7:0] PTU_OFF_INNER_SS = 8'h98;
  localparam int PTU_NREG = 40;
  // Operation codes in CTRL[2:0]
  localparam logic [2:0] PTU_OP_CALL = 3'h0;
  localparam logic [2:0] PTU_OP_NEAR_RET = 3'h1;
  localparam logic [2:0] PTU_OP_FAR_RET = 3'h2;
  localparam logic [2:0] PTU_OP_ENTER = 3'h3;
  localparam logic [2:0] PTU_OP_EXIT = 3'h4;
  // Fault codes
  localparam logic [3:0] PTU_F_NONE = 4'h0;
  localparam logic [3:0] PTU_F_GP_LIMIT = 4'h1;
  localparam logic [3:0] PTU_F_GP_PRIV = 4'h2;
  localparam logic [3:0] PTU_F_GP_CODE = 4'h3;
  localparam logic [3:0] PTU_F_GP_STACK = 4'h4;
  localparam logic [3:0] PTU_F_GP_NULL = 4'h5;
  localparam logic [3:0] PTU_F_GP_CANON = 4'h6;
  localparam logic [3:0] PTU_F_BAD_OP = 4'h7;
  // Slot strides and selector offsets
  localparam logic [63:0] PTU_STRIDE32 = 64'h4;
  localparam logic [63:0] PTU_STRIDE64 = 64'h8;
  localparam logic [15:0] PTU_SEL_ENT_SS = 16'h0008;
  localparam logic [15:0] PTU_SEL_EXIT_CS = 16'h0010;
  localparam logic [15:0] PTU_SEL_EXIT_SS = 16'h0018;
  localparam logic [15:0] PTU_SEL_EXIT_CS64 = 16'h0020;
  localparam logic [15:0] PTU_SEL_EXIT_SS64 = 16'h0028;
  localparam logic [1:0] PTU_CPL_USER = 2'h3;
  localparam logic [1:0] PTU_CPL_KERNEL = 2'h0;
  localparam logic [31:0] PTU_FLAT_LIMIT = 32'hffffffff;
  localparam logic [1:0] PTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTU_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PTU_ST_IDLE = 2'b00,
    PTU_ST_EXEC = 2'b01,
    PTU_ST_COMMIT = 2'b10
  } ptu_state_t;
endpackage

// ==== dv/ptu_core_checker.sv ====
// Bus protocol checker bound to the transfer unit
`timescale 1ns/1ps
module ptu_core_checker
  import ptu_pkg::*;
(
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_b, // Reset
  input wire logic [7:0] i_awaddr, // AW addr
  input wire logic i_awvalid, // AW valid
  input wire logic o_awready, // AW ready
  input wire logic [31:0] i_wdata, // W data
  input wire logic [3:0] i_wstrb, // W strobes
  input wire logic i_wvalid, // W valid
  input wire logic o_wready, // W ready
  input wire logic [1:0] o_bresp, // B resp
  input wire logic o_bvalid, // B valid
  input wire logic i_bready, // B ready
  input wire logic [7:0] i_araddr, // AR addr
  input wire logic i_arvalid, // AR valid
  input wire logic o_arready, // AR ready
  input wire logic [31:0] o_rdata, // R data
  input wire logic [1:0] o_rresp, // R resp
  input wire logic o_rvalid, // R valid
  input wire logic i_rready // R ready
);
  wire logic wr_hs = i_awvalid && o_awready && i_wvalid && o_wready;
  wire logic ar_hs = i_arvalid && o_arready;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // ****************
  // Bus properties
  // ****************
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("bvalid dropped early");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data not held");
  a_read_answer: assert property (ar_hs |=> o_rvalid)
    else $error("read answer late");
  a_rvalid_cause: assert property ($rose(o_rvalid) |-> $past(ar_hs))
    else $error("read answer without request");
  a_write_answer: assert property (wr_hs |-> ##2 o_bvalid)
    else $error("write answer late");
  a_bad_write: assert property (wr_hs && i_awaddr >= 8'ha0 |-> ##2
    o_bresp == PTU_RESP_SLVERR) else $error("unmapped write accepted");
  a_bad_read: assert property (ar_hs && i_araddr >= 8'ha0 |=>
    o_rresp == PTU_RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read accepted");
  a_busy_block: assert property (
    wr_hs && i_awaddr == PTU_OFF_CTRL |=> (!o_awready && !o_wready)[*3])
    else $error("write taken while operation runs");
  c_write: cover property (o_bvalid && i_bready);
  c_refused: cover property (o_rvalid && o_rresp == PTU_RESP_SLVERR);
  c_start: cover property (wr_hs && i_awaddr == PTU_OFF_CTRL);
endmodule

bind ptu_core ptu_core_checker i_ptu_core_checker (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
  .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_rready(i_rready)
);

// ==== dv/privilege_transfer_unit_bench.sv ====
// Register-level bench for the privilege transfer unit
`timescale 1ns/1ps
module privilege_transfer_unit_bench
  import ptu_pkg::*;
;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] rd_q;
  logic [1:0] rr_q;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  ptu_core i_ptu_core (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  // ****************
  // Bus tasks
  // ****************
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!got) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        rr_q = bresp;
        got = 1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit got;
    got = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!got) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        rd_q = rdata;
        rr_q = rresp;
        got = 1;
      end
    end
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(rd_q, e);
  endtask
  // Start an operation and poll until idle with done set
  task automatic op(input logic [31:0] c);
    int n;
    wr(PTU_OFF_CTRL, c);
    n = 0;
    do begin
      rd(PTU_OFF_STATUS);
      n++;
    end while (rd_q[1:0] !== 2'h2 && n < 50);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    ck(8'h08, 32'h0);
    wr(8'h04, 32'hff);
    ck(8'h04, 32'h0);
    rd(8'ha0);
    check({30'h0, rr_q}, {30'h0, PTU_RESP_SLVERR});
    wr(8'hfc, 32'h1);
    check({30'h0, rr_q}, {30'h0, PTU_RESP_SLVERR});
    wr(8'h08, 32'h3);
    wr(8'h28, 32'h10);
    wr(8'h2c, 32'h12345678);
    wr(8'h30, 32'hdead);
    wr(8'h34, 32'h8000);
    wr(8'h38, 32'hbeef);
    op(32'h3);
    ck(8'h04, 32'h2);
    ck(8'h0c, 32'h10);
    ck(8'h10, 32'h18);
    ck(8'h18, 32'h12345678);
    ck(8'h1c, 32'h0);
    ck(8'h20, 32'h8000);
    ck(8'h24, 32'h0);
    wr(8'h08, 32'h3);
    op(32'h4);
    ck(8'h04, 32'h322);
    ck(8'h0c, 32'h10);
    wr(8'h08, 32'h0);
    wr(8'h3c, 32'h400);
    wr(8'h44, 32'h900);
    op(32'h4);
    ck(8'h0c, 32'h20);
    ck(8'h10, 32'h28);
    ck(8'h18, 32'h400);
    ck(8'h20, 32'h900);
    ck(8'h08, 32'h3);
    wr(8'h40, 32'h7);
    wr(8'h48, 32'h9);
    for (int w = 0; w < 2; w++) begin
      wr(8'h08, 32'hc);
      op(w ? 32'hc : 32'h4);
      ck(8'h0c, w ? 32'h30 : 32'h20);
      ck(8'h10, w ? 32'h38 : 32'h28);
      ck(8'h1c, w ? 32'h7 : 32'h0);
      ck(8'h24, w ? 32'h9 : 32'h0);
      ck(8'h08, w ? 32'hf : 32'h7);
    end
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h1000);
    wr(8'h54, 32'h1001);
    op(32'h1);
    ck(8'h04, 32'h12);
    ck(8'h18, 32'h400);
    wr(8'h54, 32'h1000);
    op(32'h1);
    ck(8'h18, 32'h1000);
    wr(8'h08, 32'hf);
    wr(8'h0c, 32'h33);
    wr(8'h10, 32'h2b);
    wr(8'h18, 32'h100);
    wr(8'h20, 32'h7000);
    wr(8'h4c, 32'h9000);
    wr(8'h90, 32'h00150008);
    wr(8'h94, 32'h4000);
    wr(8'h98, 32'h77);
    op(32'h0);
    ck(8'h10, 32'h1);
    ck(8'h20, 32'h8fe0);
    ck(8'h54, 32'h100);
    ck(8'h5c, 32'h33);
    ck(8'h64, 32'h7000);
    ck(8'h6c, 32'h2b);
    ck(8'h0c, 32'h9);
    ck(8'h18, 32'h4000);
    ck(8'h04, 32'hd02);
    wr(8'h7c, 32'h6e0);
    wr(8'h80, 32'h23);
    wr(8'h84, 32'h2b);
    wr(8'h88, 32'h3b);
    wr(8'h78, 32'hffffff7b);
    op(32'h2);
    ck(8'h0c, 32'h9);
    ck(8'h80, 32'h23);
    wr(8'h78, 32'hffffff7f);
    op(32'h2);
    ck(8'h0c, 32'h33);
    ck(8'h18, 32'h100);
    ck(8'h10, 32'h2b);
    ck(8'h20, 32'h7000);
    ck(8'h08, 32'hf);
    ck(8'h80, 32'h0);
    ck(8'h84, 32'h2b);
    ck(8'h88, 32'h3b);
    op(32'h3);
    ck(8'h04, 32'hf62);
    wr(8'h30, 32'h1);
    wr(8'h38, 32'h2);
    op(32'h3);
    ck(8'h14, 32'hffffffff);
    ck(8'h1c, 32'h1);
    ck(8'h08, 32'hc);
    wr(8'h74, 32'h10);
    wr(8'h6c, 32'h3);
    op(32'h2);
    ck(8'h04, 32'hc52);
    wr(8'h6c, 32'h2b);
    op(32'h2);
    ck(8'h20, 32'h7010);
    results();
  end
endmodule
